// ### gcm_pkg.sv
package gcm_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int ENTRY_HOLD_MS = 1000;
  localparam int EDIT_HOLD_MS = 1000;
  localparam int IDLE_MIN = 3;
  localparam int IDLE_MS = IDLE_MIN * 60 * 1000;
  localparam int SEC_MS = 1000;
  localparam int ENTRY_TICKS = ENTRY_HOLD_MS * 1000 / TICK_US;
  localparam int EDIT_TICKS = EDIT_HOLD_MS * 1000 / TICK_US;
  localparam int IDLE_TICKS = IDLE_MS * 1000 / TICK_US;
  localparam int SEC_TICKS = SEC_MS * 1000 / TICK_US;
  localparam int TICK_W = 17;
  localparam int MS_W = 18;
  localparam int SEC_W = 10;
  localparam int OPT_W = 7;
  localparam int FN_W = 2;
  localparam int NUM_FUNC = 4;
  localparam int NUM_PINS = 6;
  // ==========================================
  // pin positions in the synchronised vector
  localparam int PIN_UP = 0;
  localparam int PIN_DOWN = 1;
  localparam int PIN_ENTER = 2;
  localparam int PIN_LIM_MOTOR = 3;
  localparam int PIN_LIM_FAR = 4;
  localparam int PIN_SHADOW = 5;
  // ==========================================
  // functions and options
  localparam logic [FN_W-1:0] FN_HAND = 2'h0;
  localparam logic [FN_W-1:0] FN_DUAL = 2'h1;
  localparam logic [FN_W-1:0] FN_ACT = 2'h2;
  localparam logic [FN_W-1:0] FN_AUX = 2'h3;
  localparam logic [FN_W-1:0] FN_LAST = 2'h3;
  localparam logic [OPT_W-1:0] OPT_RESET = 7'h00;
  localparam logic [OPT_W-1:0] HAND_LEFT = 7'h01;
  localparam logic [OPT_W-1:0] DUAL_MAX = 7'h01;
  localparam logic [OPT_W-1:0] HAND_MAX = 7'h01;
  localparam logic [OPT_W-1:0] ACT_SEC_MAX = 7'h3b;
  localparam logic [OPT_W-1:0] ACT_MIN_MAX = 7'h44;
  localparam logic [OPT_W-1:0] AUX_OFF = 7'h00;
  localparam logic [OPT_W-1:0] AUX_MAGLOCK = 7'h01;
  localparam logic [OPT_W-1:0] AUX_TICKET = 7'h02;
  localparam logic [OPT_W-1:0] AUX_STROBE = 7'h03;
  localparam logic [SEC_W-1:0] SECS_PER_MIN = 10'h03c;

  typedef enum logic [2:0] {MS_OFF, MS_FUNC, MS_OPT, MS_EDIT, MS_STORED} gcm_menu_t;

  function automatic logic [OPT_W-1:0] gcm_opt_max(input logic [FN_W-1:0] f);
    case (f)
      FN_HAND: gcm_opt_max = HAND_MAX;
      FN_DUAL: gcm_opt_max = DUAL_MAX;
      FN_ACT: gcm_opt_max = ACT_MIN_MAX;
      default: gcm_opt_max = AUX_STROBE;
    endcase
  endfunction

  // option 1..59 are seconds, 60..68 are 1..9 minutes
  function automatic logic [SEC_W-1:0] gcm_act_secs(input logic [OPT_W-1:0] o);
    logic [SEC_W-1:0] m;
    m = SEC_W'(o) - SEC_W'(ACT_SEC_MAX);
    if (o <= ACT_SEC_MAX) begin
      gcm_act_secs = SEC_W'(o);
    end else begin
      gcm_act_secs = SEC_W'(m * SECS_PER_MIN);
    end
  endfunction
endpackage

// ### gcm_menu_fsm.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module gcm_menu_fsm import gcm_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int IDLE_LIMIT = IDLE_TICKS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic btn_up_in,
  input wire logic btn_down_in,
  input wire logic btn_enter_in,
  input wire logic limit_motor_in,
  input wire logic limit_far_in,
  input wire logic shadow_loop_in,
  input wire logic motion_pending_in,
  input wire logic gate_moving_in,
  input wire logic gate_opening_in,
  output logic prog_led_out,
  output logic [OPT_W-1:0] disp_value_out,
  output logic disp_dp_out,
  output logic disp_flash_out,
  output logic nv_write_out,
  output logic [FN_W-1:0] nv_addr_out,
  output logic [OPT_W-1:0] nv_data_out,
  output logic open_limit_out,
  output logic close_limit_out,
  output logic dual_link_en_out,
  output logic mid_stop_en_out,
  output logic hold_open_out,
  output logic auto_close_out,
  output logic aux_relay_out
);
  // ==========================================
  // pin synchronisers
  logic [NUM_PINS-1:0] pin_raw, pin_s1_reg, pin_reg, pin_prev_reg;
  assign pin_raw = {shadow_loop_in, limit_far_in, limit_motor_in, btn_enter_in, btn_down_in, btn_up_in};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
          pin_prev_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_reg[gi] <= pin_s1_reg[gi];
          pin_prev_reg[gi] <= pin_reg[gi];
        end
      end
    end
  endgenerate
  logic both, both_prev, both_rise, up_rise, down_rise, ent_rise, any_press;
  assign both = pin_reg[PIN_UP] & pin_reg[PIN_DOWN];
  assign both_prev = pin_prev_reg[PIN_UP] & pin_prev_reg[PIN_DOWN];
  assign both_rise = both & ~both_prev;
  // single steps only when the other arrow is released
  assign up_rise = pin_reg[PIN_UP] & ~pin_prev_reg[PIN_UP] & ~pin_reg[PIN_DOWN];
  assign down_rise = pin_reg[PIN_DOWN] & ~pin_prev_reg[PIN_DOWN] & ~pin_reg[PIN_UP];
  assign ent_rise = pin_reg[PIN_ENTER] & ~pin_prev_reg[PIN_ENTER];
  assign any_press = (pin_reg[PIN_UP] & ~pin_prev_reg[PIN_UP]) | (pin_reg[PIN_DOWN] & ~pin_prev_reg[PIN_DOWN]) | ent_rise;
  // ==========================================
  // millisecond and second enables
  logic [TICK_W-1:0] div_reg;
  logic [SEC_W-1:0] ms_reg;
  logic tick, sec_tick;
  assign tick = (div_reg == TICK_W'(TICK_CYCLES - 1));
  assign sec_tick = tick & (ms_reg == SEC_W'(SEC_TICKS - 1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms_reg <= '0;
    end else if (sec_tick) begin
      ms_reg <= '0;
    end else if (tick) begin
      ms_reg <= ms_reg + 1'b1;
    end
  end
  // ==========================================
  // menu state
  gcm_menu_t state_reg, state_next;
  logic [FN_W-1:0] func_reg;
  logic [OPT_W-1:0] edit_reg;
  logic [OPT_W-1:0] setting_reg [NUM_FUNC];
  logic [SEC_W-1:0] entry_reg;
  logic [SEC_W-1:0] ehold_reg;
  logic [MS_W-1:0] idle_reg;
  logic entry_block_reg, ehold_arm_reg, in_prog, entry_done, edit_done, idle_done, store;
  logic [OPT_W-1:0] opt_max;
  assign in_prog = (state_reg != MS_OFF);
  assign entry_done = tick & (entry_reg == SEC_W'(ENTRY_TICKS - 1));
  assign edit_done = tick & ehold_arm_reg & (ehold_reg == SEC_W'(EDIT_TICKS - 1));
  assign idle_done = tick & (idle_reg == MS_W'(IDLE_LIMIT - 1)) & ~any_press;
  assign store = (state_reg == MS_EDIT) & ent_rise & ~both;
  assign opt_max = gcm_opt_max(func_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MS_OFF: begin
        if (entry_done) begin
          state_next = MS_FUNC;
        end
      end
      MS_FUNC: begin
        if (ent_rise) begin
          state_next = MS_OPT;
        end
      end
      MS_OPT: begin
        if (edit_done) begin
          state_next = MS_EDIT;
        end else if (up_rise | down_rise) begin
          state_next = MS_FUNC;
        end
      end
      MS_EDIT: begin
        if (ent_rise) begin
          state_next = MS_STORED;
        end
      end
      MS_STORED: begin
        if (ent_rise | up_rise | down_rise) begin
          state_next = MS_FUNC;
        end
      end
      default: state_next = MS_OFF;
    endcase
    if (in_prog & (both_rise | idle_done)) begin
      state_next = MS_OFF;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= MS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // entry hold; after an exit the buttons must be released first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      entry_reg <= '0;
      entry_block_reg <= 1'b0;
    end else begin
      if (!both) begin
        entry_block_reg <= 1'b0;
      end else if (in_prog) begin
        entry_block_reg <= 1'b1;
      end
      if (!both || in_prog || entry_block_reg) begin
        entry_reg <= '0;
      end else if (tick) begin
        entry_reg <= entry_reg + 1'b1;
      end
    end
  end

  // enter hold only counts from a fresh press made while an option shows
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ehold_reg <= '0;
      ehold_arm_reg <= 1'b0;
    end else if (state_reg != MS_OPT || !pin_reg[PIN_ENTER]) begin
      ehold_reg <= '0;
      ehold_arm_reg <= 1'b0;
    end else begin
      if (ent_rise) begin
        ehold_arm_reg <= 1'b1;
      end
      if (ehold_arm_reg && tick) begin
        ehold_reg <= ehold_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_reg <= '0;
    end else if (!in_prog || any_press || idle_done) begin
      idle_reg <= '0;
    end else if (tick) begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      func_reg <= FN_HAND;
    end else if (state_reg == MS_FUNC && up_rise) begin
      func_reg <= (func_reg == FN_LAST) ? FN_HAND : func_reg + 1'b1;
    end else if (state_reg == MS_FUNC && down_rise) begin
      func_reg <= (func_reg == FN_HAND) ? FN_LAST : func_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edit_reg <= OPT_RESET;
    end else if (state_reg == MS_FUNC && ent_rise) begin
      edit_reg <= setting_reg[func_reg];
    end else if (state_reg == MS_EDIT && up_rise) begin
      edit_reg <= (edit_reg >= opt_max) ? OPT_RESET : edit_reg + 1'b1;
    end else if (state_reg == MS_EDIT && down_rise) begin
      edit_reg <= (edit_reg == OPT_RESET) ? opt_max : edit_reg - 1'b1;
    end
  end

  // settings held here; the write port mirrors each store out
  generate
    for (gi = 0; gi < NUM_FUNC; gi++) begin : g_set
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          setting_reg[gi] <= OPT_RESET;
        end else if (store && func_reg == FN_W'(gi)) begin
          setting_reg[gi] <= edit_reg;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nv_write_out <= 1'b0;
      nv_addr_out <= FN_HAND;
      nv_data_out <= OPT_RESET;
    end else begin
      nv_write_out <= store;
      if (store) begin
        nv_addr_out <= func_reg;
        nv_data_out <= edit_reg;
      end
    end
  end
  // ==========================================
  // display and lamp
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_led_out <= 1'b0;
      disp_value_out <= OPT_RESET;
      disp_dp_out <= 1'b0;
      disp_flash_out <= 1'b0;
    end else begin
      prog_led_out <= in_prog;
      disp_value_out <= (state_reg == MS_FUNC) ? OPT_W'(func_reg) : edit_reg;
      disp_dp_out <= in_prog & (state_reg != MS_FUNC);
      disp_flash_out <= (state_reg == MS_EDIT);
    end
  end
  // ==========================================
  // gate settings
  logic left_hand, dual_on, open_lim;
  assign left_hand = (setting_reg[FN_HAND] == HAND_LEFT);
  assign dual_on = (setting_reg[FN_DUAL] != OPT_RESET);
  assign open_lim = left_hand ? pin_reg[PIN_LIM_FAR] : pin_reg[PIN_LIM_MOTOR];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      open_limit_out <= 1'b0;
      close_limit_out <= 1'b0;
      dual_link_en_out <= 1'b0;
      mid_stop_en_out <= 1'b1;
      hold_open_out <= 1'b0;
    end else begin
      open_limit_out <= open_lim;
      close_limit_out <= left_hand ? pin_reg[PIN_LIM_MOTOR] : pin_reg[PIN_LIM_FAR];
      dual_link_en_out <= dual_on;
      mid_stop_en_out <= ~dual_on;
      hold_open_out <= pin_reg[PIN_SHADOW];
    end
  end
  // auto-close countdown; the shadow loop restarts it so the gate stays open
  logic [SEC_W-1:0] act_reg;
  logic open_prev_reg, act_fire;
  assign act_fire = sec_tick & (act_reg == SEC_W'(1)) & ~pin_reg[PIN_SHADOW] & open_lim;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_reg <= '0;
      open_prev_reg <= 1'b0;
      auto_close_out <= 1'b0;
    end else begin
      open_prev_reg <= open_lim;
      auto_close_out <= act_fire;
      if (!open_lim) begin
        act_reg <= '0;
      end else if ((open_lim && !open_prev_reg) || pin_reg[PIN_SHADOW]) begin
        act_reg <= gcm_act_secs(setting_reg[FN_ACT]);
      end else if (sec_tick && act_reg != '0) begin
        act_reg <= act_reg - 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_relay_out <= 1'b0;
    end else begin
      case (setting_reg[FN_AUX])
        AUX_MAGLOCK: aux_relay_out <= motion_pending_in | (gate_moving_in & gate_opening_in);
        AUX_TICKET: aux_relay_out <= (gate_moving_in & gate_opening_in) | open_lim;
        AUX_STROBE: aux_relay_out <= motion_pending_in | gate_moving_in;
        default: aux_relay_out <= 1'b0;
      endcase
    end
  end
  // ==========================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_entry_held;
    state_reg == MS_OFF && entry_done;
  endsequence
  sequence s_store_press;
    state_reg == MS_EDIT && ent_rise && !both;
  endsequence
  property p_entry;
    $rose(in_prog) |-> $past(both) && $past(entry_reg) == SEC_W'(ENTRY_TICKS - 1);
  endproperty
  a_entry: assert property (p_entry) else $error("menu entered without full hold");
  property p_entry_go;
    s_entry_held |=> state_reg == MS_FUNC ##1 prog_led_out;
  endproperty
  a_entry_go: assert property (p_entry_go) else $error("hold did not open menu");
  property p_led;
    ##1 prog_led_out == ($past(state_reg) != MS_OFF);
  endproperty
  a_led: assert property (p_led) else $error("program lamp wrong");
  property p_exit;
    in_prog && both_rise |=> state_reg == MS_OFF ##1 !prog_led_out;
  endproperty
  a_exit: assert property (p_exit) else $error("up+down did not exit");
  property p_idle;
    in_prog && idle_done |=> state_reg == MS_OFF && idle_reg == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle exit missed");
  property p_step;
    state_reg == MS_FUNC && up_rise && func_reg != FN_LAST && !both_rise |=> func_reg == $past(func_reg) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("function step wrong");
  property p_show;
    state_reg == MS_FUNC && ent_rise && !both_rise |=> state_reg == MS_OPT && edit_reg == setting_reg[func_reg];
  endproperty
  a_show: assert property (p_show) else $error("stored option not shown");
  property p_dp;
    state_reg == MS_OPT |=> disp_dp_out && !disp_flash_out;
  endproperty
  a_dp: assert property (p_dp) else $error("decimal points not lit");
  property p_store;
    s_store_press |=> nv_write_out && nv_data_out == $past(edit_reg) ##1 !disp_flash_out;
  endproperty
  a_store: assert property (p_store) else $error("store failed");
  property p_edit_range;
    state_reg == MS_EDIT |-> edit_reg <= opt_max;
  endproperty
  a_edit_range: assert property (p_edit_range) else $error("option out of range");
  property p_dual;
    ##1 mid_stop_en_out != dual_link_en_out;
  endproperty
  a_dual: assert property (p_dual) else $error("mid-travel stop not tied to dual");
  property p_hand;
    ##1 open_limit_out == (($past(setting_reg[FN_HAND]) == HAND_LEFT) ? $past(pin_reg[PIN_LIM_FAR]) : $past(pin_reg[PIN_LIM_MOTOR]));
  endproperty
  a_hand: assert property (p_hand) else $error("open limit mapping wrong");
  property p_close;
    act_fire |=> auto_close_out ##1 !auto_close_out;
  endproperty
  a_close: assert property (p_close) else $error("auto close pulse wrong");
  property p_shadow;
    pin_reg[PIN_SHADOW] |=> !auto_close_out && hold_open_out;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow loop ignored");
endmodule // gcm_menu_fsm

// ### gcm_partner.sv
`timescale 1ns/1ns
// ==========================================
// installer buttons, limit switches, loops and motor levels
module gcm_partner (
  input wire logic clk_in,
  output logic up_out,
  output logic down_out,
  output logic enter_out,
  output logic lim_motor_out,
  output logic lim_far_out,
  output logic shadow_out,
  output logic pending_out,
  output logic moving_out,
  output logic opening_out
);
  initial begin
    {enter_out, down_out, up_out} = 3'h0;
    {lim_motor_out, lim_far_out, shadow_out, pending_out, moving_out, opening_out} = 6'h00;
  end

  // ==========================================
  // buttons: b is {enter, down, up}, held cyc edges
  // released buttons read low, contacts have pull-downs
  task automatic press(input logic [2:0] b, input int cyc);
    @(posedge clk_in);
    {enter_out, down_out, up_out} <= b;
    repeat (cyc) @(posedge clk_in);
    {enter_out, down_out, up_out} <= 3'h0;
    // gap longer than sync plus state plus output delay
    repeat (10) @(posedge clk_in);
  endtask

  // ==========================================
  // gate side: {motor, far, shadow, pending, moving, opening}
  task automatic env(input logic [5:0] v);
    @(posedge clk_in);
    {lim_motor_out, lim_far_out, shadow_out, pending_out, moving_out, opening_out} <= v;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // gcm_partner

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top import gcm_pkg::*; ;
  // ==========================================
  // signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic up, down, enter, lm, lf, sh, pe, mv, op;
  logic led, dp, flash, nvw, ol, cl, dl, ms, ho, ac, relay;
  logic [OPT_W-1:0] dval;
  logic [OPT_W-1:0] nvd;
  logic [FN_W-1:0] nva;
  int err_total = 0;
  int num_checks = 0;
  int nv_cnt = 0;
  int ac_cnt = 0;
  int i;
  // short tick keeps one second at 4000 cycles
  localparam int HOLD = 4200;

  always #4 clk_in = ~clk_in;

  // pulses counted so a stretched pulse shows up
  always @(posedge clk_in) begin
    if (nvw === 1'b1) nv_cnt++;
    if (ac === 1'b1) ac_cnt++;
  end

  gcm_partner p (.clk_in(clk_in), .up_out(up), .down_out(down), .enter_out(enter),
    .lim_motor_out(lm), .lim_far_out(lf), .shadow_out(sh), .pending_out(pe),
    .moving_out(mv), .opening_out(op));

  gcm_menu_fsm #(.TICK_CYCLES(4), .IDLE_LIMIT(2000)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .btn_up_in(up), .btn_down_in(down), .btn_enter_in(enter), .limit_motor_in(lm),
    .limit_far_in(lf), .shadow_loop_in(sh), .motion_pending_in(pe), .gate_moving_in(mv),
    .gate_opening_in(op), .prog_led_out(led), .disp_value_out(dval), .disp_dp_out(dp),
    .disp_flash_out(flash), .nv_write_out(nvw), .nv_addr_out(nva), .nv_data_out(nvd),
    .open_limit_out(ol), .close_limit_out(cl), .dual_link_en_out(dl), .mid_stop_en_out(ms),
    .hold_open_out(ho), .auto_close_out(ac), .aux_relay_out(relay));

  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic goto_fn(input logic [1:0] fn);
    for (int k = 0; k < 4; k++) begin
      if (dval[1:0] !== fn) p.press(3'h1, 4);
    end
  endtask

  // old is the option stored before this session
  task automatic prog(input logic [1:0] fn, input logic [2:0] b, input logic [6:0] old, input logic [6:0] val);
    int c0;
    goto_fn(fn);
    p.press(3'h4, 4);
    chk("dp in option", 7'(1), 7'(dp));
    chk("stored option", old, dval);
    p.press(3'h4, HOLD);
    chk("flash", 7'(1), 7'(flash));
    p.press(b, 4);
    chk("edited option", val, dval);
    c0 = nv_cnt;
    p.press(3'h4, 4);
    chk("nv pulses", 7'(1), 7'(nv_cnt - c0));
    chk("nv addr", 7'(fn), 7'(nva));
    chk("nv data", val, nvd);
    chk("flash off", 7'(0), 7'(flash));
    p.press(3'h4, 4);
    chk("dp off", 7'(0), 7'(dp));
    chk("function shown", 7'(fn), dval);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("lamp after reset", 7'(0), 7'(led));
    chk("dual after reset", 7'(0), 7'(dl));
    chk("mid stop after reset", 7'(1), 7'(ms));
    p.env(6'h20);
    chk("open limit right", 7'(1), 7'(ol));
    chk("close limit right", 7'(0), 7'(cl));
    p.env(6'h00);
    $display("test reset done");

    p.press(3'h3, 2000);
    chk("lamp short hold", 7'(0), 7'(led));
    p.press(3'h3, HOLD);
    chk("lamp in menu", 7'(1), 7'(led));
    chk("first function", 7'(FN_HAND), dval);
    p.press(3'h2, 4);
    chk("down wraps", 7'(FN_LAST), dval);
    p.press(3'h1, 4);
    chk("up wraps", 7'(FN_HAND), dval);
    $display("test entry done");

    prog(FN_DUAL, 3'h1, OPT_RESET, DUAL_MAX);
    chk("dual link", 7'(1), 7'(dl));
    chk("mid stop off", 7'(0), 7'(ms));
    prog(FN_HAND, 3'h1, OPT_RESET, HAND_LEFT);
    p.env(6'h10);
    chk("open limit left", 7'(1), 7'(ol));
    p.env(6'h20);
    chk("close limit left", 7'(1), 7'(cl));
    chk("open limit idle", 7'(0), 7'(ol));
    p.env(6'h00);
    prog(FN_ACT, 3'h1, OPT_RESET, 7'h01);
    prog(FN_AUX, 3'h2, OPT_RESET, AUX_STROBE);
    $display("test settings done");

    p.press(3'h4, 4);
    p.press(3'h4, HOLD);
    chk("flash before exit", 7'(1), 7'(flash));
    p.press(3'h3, 4);
    chk("lamp exit from edit", 7'(0), 7'(led));
    chk("flash after exit", 7'(0), 7'(flash));
    $display("test exit done");

    p.press(3'h3, HOLD);
    p.press(3'h1, 4);
    repeat (6000) @(posedge clk_in);
    chk("lamp before idle", 7'(1), 7'(led));
    p.press(3'h1, 4);
    repeat (6000) @(posedge clk_in);
    chk("lamp idle restarted", 7'(1), 7'(led));
    repeat (3000) @(posedge clk_in);
    chk("lamp idle exit", 7'(0), 7'(led));
    $display("test idle done");

    p.env(6'h18);
    repeat (5000) @(posedge clk_in);
    chk("hold open", 7'(1), 7'(ho));
    chk("no close while held", 7'(0), 7'(ac_cnt));
    p.env(6'h10);
    chk("hold open off", 7'(0), 7'(ho));
    for (i = 0; i < HOLD && ac_cnt == 0; i++) @(posedge clk_in);
    if (ac_cnt == 0) begin
      err_total++;
      $display("ERROR auto_close expected 1 seen 0");
      finish_test();
    end
    repeat (20) @(posedge clk_in);
    chk("auto close pulses", 7'(1), 7'(ac_cnt));
    p.env(6'h00);
    $display("test auto close done");

    p.env(6'h02);
    chk("strobe moving", 7'(1), 7'(relay));
    p.env(6'h04);
    chk("strobe pending", 7'(1), 7'(relay));
    p.env(6'h00);
    chk("strobe idle", 7'(0), 7'(relay));
    p.press(3'h3, HOLD);
    chk("lamp re-entry", 7'(1), 7'(led));
    prog(FN_AUX, 3'h2, AUX_STROBE, AUX_TICKET);
    p.env(6'h03);
    chk("ticket opening", 7'(1), 7'(relay));
    p.env(6'h02);
    chk("ticket closing", 7'(0), 7'(relay));
    p.env(6'h10);
    chk("ticket at open", 7'(1), 7'(relay));
    p.env(6'h00);
    prog(FN_AUX, 3'h2, AUX_TICKET, AUX_MAGLOCK);
    p.env(6'h04);
    chk("maglock pending", 7'(1), 7'(relay));
    p.env(6'h02);
    chk("maglock closing", 7'(0), 7'(relay));
    p.env(6'h03);
    chk("maglock opening", 7'(1), 7'(relay));
    $display("test relay done");
    finish_test();
  end
endmodule // tb_top
